// ### core/sfp_defs.vh
/*
  Constants for the serial flash parameter table: the read command, the
  phase lengths of the serial transfer, the table location and every
  fixed byte of the slice from relative offset 0ch to 23h.
  Assumes it is included by bare name from the design files under core/.
*/
// Overview of operation
// - Offset 0ch reads 08h, dual-out cycles
// - Offset 0dh reads 3bh, dual-out opcode
// - Offset 0eh reads 80h, dual-io cycles
// - Offset 0fh reads bbh, dual-io opcode
// - Offset 10h reads eeh, all-phase unsupported
// - All-phase fields 111b/11111b, opcodes ffh
// - Reserved bytes 11h to 19h read ffh
// - Erase type 1: 0ch size, 20h opcode
// - Erase type 2: 10h size, d8h opcode
// - Erase type 3: 12h size, d8h opcode
// - Erase type 4 unsupported: 00h, ffh
`ifndef SFP_DEFS_VH
`define SFP_DEFS_VH

// Serial command and phase lengths
`define SFP_OP_READ_PARAM 8'h5a
`define SFP_CMD_LAST_BIT 5'h07
`define SFP_ADDR_LAST_BIT 5'h17
`define SFP_DUMMY_LAST 5'h07
`define SFP_BYTE_LAST_BIT 5'h07

// Pin synchroniser reset levels, order {cs_n, sck, si}
`define SFP_PIN_RESET 3'h4

// Relative offset 00h of the table in the parameter address space
`define SFP_TABLE_BASE 24'h001120

// Table offsets
`define SFP_OFS_SLICE_LO 8'h0c
`define SFP_OFS_SLICE_HI 8'h23
`define SFP_OFS_DUAL_OUT_CYC 8'h0c
`define SFP_OFS_DUAL_OUT_OP 8'h0d
`define SFP_OFS_DUAL_IO_CYC 8'h0e
`define SFP_OFS_DUAL_IO_OP 8'h0f
`define SFP_OFS_ALL_SUPPORT 8'h10
`define SFP_OFS_RSVD_LO 8'h11
`define SFP_OFS_RSVD_HI 8'h19
`define SFP_OFS_DUAL_ALL_CYC 8'h16
`define SFP_OFS_DUAL_ALL_OP 8'h17
`define SFP_OFS_QUAD_ALL_CYC 8'h1a
`define SFP_OFS_QUAD_ALL_OP 8'h1b
`define SFP_OFS_ERASE1_SIZE 8'h1c
`define SFP_OFS_ERASE1_OP 8'h1d
`define SFP_OFS_ERASE2_SIZE 8'h1e
`define SFP_OFS_ERASE2_OP 8'h1f
`define SFP_OFS_ERASE3_SIZE 8'h20
`define SFP_OFS_ERASE3_OP 8'h21
`define SFP_OFS_ERASE4_SIZE 8'h22
`define SFP_OFS_ERASE4_OP 8'h23

// Cycle fields: mode count in bits 7:5, dummy count in bits 4:0
`define SFP_DUAL_OUT_MODE 3'h0
`define SFP_DUAL_OUT_DUMMY 5'h08
`define SFP_DUAL_IO_MODE 3'h4
`define SFP_DUAL_IO_DUMMY 5'h00
`define SFP_ALL_MODE 3'h7
`define SFP_ALL_DUMMY 5'h1f

// Support byte fields
`define SFP_RESERVED_FUTURE_BITS 3'h7
`define SFP_QUAD_ALL_SUPPORTED 1'h0
`define SFP_DUAL_ALL_SUPPORTED 1'h0

// Opcodes and sizes
`define SFP_VAL_DUAL_OUT_OP 8'h3b
`define SFP_VAL_DUAL_IO_OP 8'hbb
`define SFP_VAL_NO_OPCODE 8'hff
`define SFP_VAL_RESERVED 8'hff
`define SFP_VAL_ERASE1_SIZE 8'h0c
`define SFP_VAL_ERASE1_OP 8'h20
`define SFP_VAL_ERASE2_SIZE 8'h10
`define SFP_VAL_ERASE2_OP 8'hd8
`define SFP_VAL_ERASE3_SIZE 8'h12
`define SFP_VAL_ERASE3_OP 8'hd8
`define SFP_VAL_ERASE4_SIZE 8'h00
`define SFP_VAL_ERASE4_OP 8'hff
`define SFP_VAL_OUTSIDE 8'hff

`endif

// ### core/sfp_table_rom.v
/*
  Fixed parameter table with a registered read port.
  Assumes the caller holds the address steady for one clock before it
  takes the data; there is no write path at all.
*/
`timescale 1ns/100ps
`include "sfp_defs.vh"

module sfp_table_rom (
  input wire ref_clk,
  input wire rst_n,
  input wire [23:0] rd_addr,
  output reg [7:0] rd_data_reg
);

  wire [23:0] rel_addr;
  wire in_slice;
  reg [7:0] rd_data_next;

  assign rel_addr = rd_addr - `SFP_TABLE_BASE;
  assign in_slice = (rel_addr[23:8] == 16'h0000) &&
                    (rel_addr[7:0] >= `SFP_OFS_SLICE_LO) &&
                    (rel_addr[7:0] <= `SFP_OFS_SLICE_HI);

  // Constant decode only, so every read of an offset gives the same byte
  always @* begin
    rd_data_next = `SFP_VAL_OUTSIDE;
    if (!in_slice) begin
      rd_data_next = `SFP_VAL_OUTSIDE;
    end else if (rel_addr[7:0] == `SFP_OFS_DUAL_OUT_CYC) begin
      rd_data_next = {`SFP_DUAL_OUT_MODE, `SFP_DUAL_OUT_DUMMY};
    end else if (rel_addr[7:0] == `SFP_OFS_DUAL_OUT_OP) begin
      rd_data_next = `SFP_VAL_DUAL_OUT_OP;
    end else if (rel_addr[7:0] == `SFP_OFS_DUAL_IO_CYC) begin
      rd_data_next = {`SFP_DUAL_IO_MODE, `SFP_DUAL_IO_DUMMY};
    end else if (rel_addr[7:0] == `SFP_OFS_DUAL_IO_OP) begin
      rd_data_next = `SFP_VAL_DUAL_IO_OP;
    end else if (rel_addr[7:0] == `SFP_OFS_ALL_SUPPORT) begin
      rd_data_next = {`SFP_RESERVED_FUTURE_BITS, `SFP_QUAD_ALL_SUPPORTED,
                      `SFP_RESERVED_FUTURE_BITS, `SFP_DUAL_ALL_SUPPORTED};
    end else if (rel_addr[7:0] == `SFP_OFS_DUAL_ALL_CYC ||
                 rel_addr[7:0] == `SFP_OFS_QUAD_ALL_CYC) begin
      rd_data_next = {`SFP_ALL_MODE, `SFP_ALL_DUMMY};
    end else if (rel_addr[7:0] == `SFP_OFS_DUAL_ALL_OP ||
                 rel_addr[7:0] == `SFP_OFS_QUAD_ALL_OP) begin
      rd_data_next = `SFP_VAL_NO_OPCODE;
    end else if (rel_addr[7:0] >= `SFP_OFS_RSVD_LO &&
                 rel_addr[7:0] <= `SFP_OFS_RSVD_HI) begin
      rd_data_next = `SFP_VAL_RESERVED;
    end else if (rel_addr[7:0] == `SFP_OFS_ERASE1_SIZE) begin
      rd_data_next = `SFP_VAL_ERASE1_SIZE;
    end else if (rel_addr[7:0] == `SFP_OFS_ERASE1_OP) begin
      rd_data_next = `SFP_VAL_ERASE1_OP;
    end else if (rel_addr[7:0] == `SFP_OFS_ERASE2_SIZE) begin
      rd_data_next = `SFP_VAL_ERASE2_SIZE;
    end else if (rel_addr[7:0] == `SFP_OFS_ERASE2_OP) begin
      rd_data_next = `SFP_VAL_ERASE2_OP;
    end else if (rel_addr[7:0] == `SFP_OFS_ERASE3_SIZE) begin
      rd_data_next = `SFP_VAL_ERASE3_SIZE;
    end else if (rel_addr[7:0] == `SFP_OFS_ERASE3_OP) begin
      rd_data_next = `SFP_VAL_ERASE3_OP;
    end else if (rel_addr[7:0] == `SFP_OFS_ERASE4_SIZE) begin
      rd_data_next = `SFP_VAL_ERASE4_SIZE;
    end else if (rel_addr[7:0] == `SFP_OFS_ERASE4_OP) begin
      rd_data_next = `SFP_VAL_ERASE4_OP;
    end else begin
      rd_data_next = `SFP_VAL_OUTSIDE;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= `SFP_VAL_OUTSIDE;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

endmodule // sfp_table_rom

// ### core/sfp_param_table.v
/*
  Serial read port for the flash parameter table. Decodes the
  parameter-read command, a 24-bit address and eight dummy clocks, then
  shifts table bytes out MSB first with the address counting up.
  Assumes SPI mode 0 or 3 from the host, with each sck high and low
  phase lasting at least four ref_clk periods, since every pin passes a
  three-stage synchroniser.
*/
`timescale 1ns/100ps
`include "sfp_defs.vh"

module sfp_param_table (
  input wire ref_clk,
  input wire rst_n,
  input wire spi_sck,
  input wire spi_cs_n,
  input wire spi_si,
  output reg spi_so_reg,
  output reg spi_so_oe_reg,
  output reg table_busy_reg,
  output reg cmd_refused_reg
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_CMD = 6'h02;
  localparam [5:0] ST_ADDR = 6'h04;
  localparam [5:0] ST_DUMMY = 6'h08;
  localparam [5:0] ST_DATA = 6'h10;
  localparam [5:0] ST_IGNORE = 6'h20;

  localparam [2:0] PIN_RESET = `SFP_PIN_RESET;
  localparam PIN_SI = 0;
  localparam PIN_SCK = 1;
  localparam PIN_CS_N = 2;

  wire [2:0] pin_in;
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  reg [2:0] sync3_reg;
  reg [2:0] stable_reg;
  wire [2:0] stable_next;

  wire sck_rise;
  wire sck_fall;
  wire si_bit;
  wire cs_idle;

  reg [5:0] state_reg;
  reg [5:0] state_next;
  reg [4:0] bit_cnt_reg;
  reg [4:0] bit_cnt_next;
  reg [23:0] shift_in_reg;
  reg [23:0] shift_in_next;
  reg [23:0] addr_reg;
  reg [23:0] addr_next;
  reg [7:0] out_shift_reg;
  reg [7:0] out_shift_next;
  reg spi_so_next;
  reg spi_so_oe_next;
  reg table_busy_next;
  reg cmd_refused_next;

  wire [7:0] rom_data;
  wire [23:0] shifted_word;
  reg [4:0] phase_last;
  wire phase_edge;
  wire phase_done;
  wire opcode_ok;

  assign pin_in = {spi_cs_n, spi_sck, spi_si};

  // Three stages per pin; a level is taken only once stages two and
  // three agree, so a metastable first stage never reaches the decode
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_pin_sync
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_reg[i] <= PIN_RESET[i];
          sync2_reg[i] <= PIN_RESET[i];
          sync3_reg[i] <= PIN_RESET[i];
          stable_reg[i] <= PIN_RESET[i];
        end else begin
          sync1_reg[i] <= pin_in[i];
          sync2_reg[i] <= sync1_reg[i];
          sync3_reg[i] <= sync2_reg[i];
          stable_reg[i] <= stable_next[i];
        end
      end
      assign stable_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i]
                                                               : stable_reg[i];
    end
  endgenerate

  assign sck_rise = stable_next[PIN_SCK] & ~stable_reg[PIN_SCK];
  assign sck_fall = ~stable_next[PIN_SCK] & stable_reg[PIN_SCK];
  // Data travels the same chain as sck, so it is settled at the edge
  assign si_bit = stable_next[PIN_SI];
  assign cs_idle = stable_next[PIN_CS_N];
  assign shifted_word = {shift_in_reg[22:0], si_bit};

  sfp_table_rom u_table_rom (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rd_addr(addr_reg),
    .rd_data_reg(rom_data)
  );

  // Last bit count of each phase
  always @* begin
    phase_last = 5'h00;
    case (state_reg)
      ST_IDLE: begin
        phase_last = 5'h00;
      end
      ST_CMD: begin
        phase_last = `SFP_CMD_LAST_BIT;
      end
      ST_ADDR: begin
        phase_last = `SFP_ADDR_LAST_BIT;
      end
      ST_DUMMY: begin
        phase_last = `SFP_DUMMY_LAST;
      end
      ST_DATA: begin
        phase_last = `SFP_BYTE_LAST_BIT;
      end
      ST_IGNORE: begin
        phase_last = 5'h00;
      end
      default: begin
        phase_last = 5'h00;
      end
    endcase
  end

  // Input phases count sck rises; the data phase counts falls so each
  // bit is settled for the host's next rise
  assign phase_edge = (state_reg == ST_DATA) ? sck_fall : sck_rise;
  assign phase_done = phase_edge && (bit_cnt_reg == phase_last);
  assign opcode_ok = (shifted_word[7:0] == `SFP_OP_READ_PARAM);

  always @* begin
    state_next = state_reg;
    if (cs_idle) begin
      // Deselect ends any transfer at once, whatever phase it was in
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_CMD;
        end
        ST_CMD: begin
          if (phase_done && opcode_ok) begin
            state_next = ST_ADDR;
          end else if (phase_done) begin
            // Anything else, writes included, leaves the table as is
            state_next = ST_IGNORE;
          end
        end
        ST_ADDR: begin
          if (phase_done) begin
            state_next = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (phase_done) begin
            state_next = ST_DATA;
          end
        end
        ST_DATA: begin
          // Bytes follow one another until the host deselects
          state_next = ST_DATA;
        end
        ST_IGNORE: begin
          state_next = ST_IGNORE;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always @* begin
    bit_cnt_next = bit_cnt_reg;
    if (cs_idle) begin
      bit_cnt_next = 5'h00;
    end else begin
      case (state_reg)
        ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA: begin
          if (phase_done) begin
            bit_cnt_next = 5'h00;
          end else if (phase_edge) begin
            bit_cnt_next = bit_cnt_reg + 5'h01;
          end
        end
        ST_IGNORE: begin
          // Nothing is counted once a command has been refused
          bit_cnt_next = bit_cnt_reg;
        end
        default: begin
          bit_cnt_next = 5'h00;
        end
      endcase
    end
  end

  // Command and address share one shifter; the address is taken whole,
  // so the table never decodes a half-shifted value
  always @* begin
    shift_in_next = shift_in_reg;
    addr_next = addr_reg;
    if (!cs_idle && (state_reg == ST_CMD || state_reg == ST_ADDR) && sck_rise) begin
      shift_in_next = shifted_word;
    end
    if (!cs_idle && state_reg == ST_ADDR && phase_done) begin
      addr_next = shifted_word;
    end else if (!cs_idle && state_reg == ST_DATA && phase_edge &&
                 bit_cnt_reg == 5'h00) begin
      // Stepping on the first bit of a byte gives the table a whole
      // byte time to answer for the next one
      addr_next = addr_reg + 24'h000001;
    end
  end

  always @* begin
    out_shift_next = out_shift_reg;
    spi_so_next = spi_so_reg;
    spi_so_oe_next = spi_so_oe_reg;
    if (cs_idle) begin
      spi_so_oe_next = 1'b0;
      spi_so_next = 1'b0;
    end else begin
      case (state_reg)
        ST_DATA: begin
          if (phase_edge) begin
            spi_so_oe_next = 1'b1;
            if (bit_cnt_reg == 5'h00) begin
              // Take the prefetched byte, then start fetching the next
              spi_so_next = rom_data[7];
              out_shift_next = {rom_data[6:0], 1'b0};
            end else begin
              spi_so_next = out_shift_reg[7];
              out_shift_next = {out_shift_reg[6:0], 1'b0};
            end
          end
        end
        ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_IGNORE: begin
          spi_so_oe_next = spi_so_oe_reg;
        end
        default: begin
          spi_so_oe_next = 1'b0;
        end
      endcase
    end
  end

  // The refusal is a single-cycle pulse on the edge that ends the command
  always @* begin
    cmd_refused_next = 1'b0;
    if (!cs_idle && state_reg == ST_CMD && phase_done && !opcode_ok) begin
      cmd_refused_next = 1'b1;
    end
    table_busy_next = (state_next != ST_IDLE);
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_in_reg <= 24'h000000;
      addr_reg <= 24'h000000;
      out_shift_reg <= 8'h00;
    end else begin
      shift_in_reg <= shift_in_next;
      addr_reg <= addr_next;
      out_shift_reg <= out_shift_next;
    end
  end

  // Port outputs, each straight from its own flop
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_so_reg <= 1'b0;
      spi_so_oe_reg <= 1'b0;
      table_busy_reg <= 1'b0;
      cmd_refused_reg <= 1'b0;
    end else begin
      spi_so_reg <= spi_so_next;
      spi_so_oe_reg <= spi_so_oe_next;
      table_busy_reg <= table_busy_next;
      cmd_refused_reg <= cmd_refused_next;
    end
  end

endmodule // sfp_param_table

// ### verification/sfp_param_table_monitor.sv
/*
  Port checker for the parameter table serial read port.
  Assumes a bind from the bench top and a host keeping sck phases of 8 clocks.
*/
`timescale 1ns/100ps
module sfp_param_table_monitor (
  input wire ref_clk,
  input wire rst_n,
  input wire spi_sck,
  input wire spi_cs_n,
  input wire spi_si,
  input wire spi_so_reg,
  input wire spi_so_oe_reg,
  input wire table_busy_reg,
  input wire cmd_refused_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_select;
    $fell(spi_cs_n);
  endsequence
  sequence s_release;
    $rose(spi_cs_n);
  endsequence
  sequence s_silent;
    !spi_so_oe_reg [*8];
  endsequence
  a_busy_on_select: assert property (s_select |-> ##[2:6] table_busy_reg)
    else $error("busy did not follow select");
  a_idle_on_release: assert property (
    s_release |-> ##[2:6] (!table_busy_reg && !spi_so_oe_reg))
    else $error("port not idle after deselect");
  a_quiet_deselect: assert property (
    spi_cs_n [*6] |-> (!spi_so_oe_reg && !spi_so_reg))
    else $error("output driven while deselected");
  a_refused_pulse: assert property (cmd_refused_reg |=> !cmd_refused_reg)
    else $error("refusal pulse too long");
  a_refused_silent: assert property (cmd_refused_reg |-> s_silent)
    else $error("output enabled after refusal");
  a_refused_busy: assert property (cmd_refused_reg |-> table_busy_reg)
    else $error("refusal outside a transfer");
  a_so_after_fall: assert property (
    (spi_so_oe_reg && $changed(spi_so_reg)) |-> !$past(spi_sck, 3))
    else $error("data changed outside sck low phase");
  a_oe_after_fall: assert property (
    $rose(spi_so_oe_reg) |-> (!$past(spi_sck, 3) && table_busy_reg))
    else $error("output enable rose at wrong time");
endmodule // sfp_param_table_monitor

// ### verification/sfp_spi_host.sv
/*
  Behavioural mode 0 host that reads the table over the serial pins.
  Assumes the bench calls xfer; sck rests low and si toggles when unused.
*/
`timescale 1ns/100ps
module sfp_spi_host (
  input wire ref_clk,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_si,
  input wire spi_so
);
  logic [7:0] rx_byte [0:31];
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Cut above zero deselects after that many sck periods, mid-byte if wanted
  task automatic xfer(input logic [7:0] op, input logic [23:0] addr, input int nb,
                      input int cut);
    logic [31:0] hdr;
    int last;
    hdr = {op, addr};
    last = (cut > 0) ? cut : 40 + nb * 8;
    spi_cs_n = 1'b0;
    for (int k = 0; k < last; k++) begin
      // Past the address the line is unused, so it toggles rather than holds
      spi_si = (k < 32) ? hdr[31 - k] : ~spi_si;
      tick(8);
      spi_sck = 1'b1;
      if (k >= 40)
        rx_byte[(k - 40) / 8] = {rx_byte[(k - 40) / 8][6:0], spi_so};
      tick(8);
      spi_sck = 1'b0;
    end
    tick(8);
    spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    tick(8);
  endtask
endmodule // sfp_spi_host

// ### verification/sfp_param_table_bench.sv
/*
  Self-checking bench for the parameter table read port.
  Assumes the design header is on the include path; the host model drives the pins.
*/
`timescale 1ns/100ps
module sfp_param_table_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  wire spi_sck, spi_cs_n, spi_si;
  wire spi_so_reg, spi_so_oe_reg, table_busy_reg, cmd_refused_reg;
  // A released data line floats to its pull-up, so an enable that never
  // rises shows up as wrong data
  wire so_line = spi_so_oe_reg ? spi_so_reg : 1'b1;
  int err_count = 0;
  int samples_checked = 0;
  int refused_cnt = 0;
  int oe_cnt = 0;
  logic [7:0] slice [0:23] = '{8'h08, 8'h3b, 8'h80, 8'hbb, 8'hee, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0c, 8'h20, 8'h10, 8'hd8,
    8'h12, 8'hd8, 8'h00, 8'hff};
  always #25 ref_clk = ~ref_clk;
  sfp_param_table uut (.ref_clk(ref_clk), .rst_n(rst_n), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so_reg(spi_so_reg),
    .spi_so_oe_reg(spi_so_oe_reg), .table_busy_reg(table_busy_reg),
    .cmd_refused_reg(cmd_refused_reg));
  sfp_spi_host host (.ref_clk(ref_clk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_si(spi_si), .spi_so(so_line));
  always @(posedge ref_clk) begin
    if (cmd_refused_reg === 1'b1) refused_cnt++;
    if (spi_so_oe_reg === 1'b1) oe_cnt++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_full_slice;
    int refused_at;
    refused_at = refused_cnt;
    host.xfer(8'h5a, 24'h00112c, 24, 0);
    check(8'(refused_cnt - refused_at), 8'h00);
    for (int i = 0; i < 24; i++)
      check(host.rx_byte[i], slice[i]);
    check({7'h00, table_busy_reg}, 8'h00);
  endtask
  // Single-byte reads back to back on the fields that report no support
  task automatic t_single_bytes;
    logic [7:0] ofs [0:6] = '{8'h10, 8'h16, 8'h17, 8'h1a, 8'h1b, 8'h22, 8'h23};
    for (int i = 0; i < 7; i++) begin
      host.xfer(8'h5a, 24'h001120 + {16'h0000, ofs[i]}, 1, 0);
      check(host.rx_byte[0], slice[ofs[i] - 8'h0c]);
    end
  endtask
  task automatic t_refused_write;
    int refused_at;
    int oe_at;
    refused_at = refused_cnt;
    oe_at = oe_cnt;
    host.xfer(8'h02, 24'h00112c, 4, 0);
    check(8'(refused_cnt - refused_at), 8'h01);
    check(8'(oe_cnt - oe_at), 8'h00);
    t_full_slice();
  endtask
  task automatic t_abort_mid_byte;
    host.xfer(8'h5a, 24'h00112e, 2, 45);
    check({7'h00, table_busy_reg}, 8'h00);
    host.xfer(8'h5a, 24'h00112e, 2, 0);
    check(host.rx_byte[0], 8'h80);
    check(host.rx_byte[1], 8'hbb);
  endtask
  task automatic t_second_reset;
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    host.tick(2);
    host.xfer(8'h5a, 24'h00113c, 2, 0);
    check(host.rx_byte[0], 8'h0c);
    check(host.rx_byte[1], 8'h20);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    host.tick(2);
    t_full_slice();
    t_single_bytes();
    t_refused_write();
    t_abort_mid_byte();
    t_second_reset();
    test_done();
  end
  // A hang is cut short here and counted as a mismatch
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    test_done();
  end
endmodule // sfp_param_table_bench
bind sfp_param_table sfp_param_table_monitor mon (.ref_clk(ref_clk), .rst_n(rst_n),
  .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so_reg(spi_so_reg),
  .spi_so_oe_reg(spi_so_oe_reg), .table_busy_reg(table_busy_reg),
  .cmd_refused_reg(cmd_refused_reg));
